/* hw/dra_pkg.sv */
package dra_pkg;
  // ==========================================
  // Register offsets, byte addresses on the debug APB
  localparam logic [11:0] off_debug_id        = 12'h000;
  localparam logic [11:0] off_watch_fault     = 12'h018;
  localparam logic [11:0] off_vector_catch    = 12'h01c;
  localparam logic [11:0] off_event_catch     = 12'h024;
  localparam logic [11:0] off_state_cache     = 12'h028;
  localparam logic [11:0] off_state_mmu       = 12'h02c;
  localparam logic [11:0] off_h2t_ext         = 12'h080;
  localparam logic [11:0] off_itr_pcs         = 12'h084;
  localparam logic [11:0] off_status_ext      = 12'h088;
  localparam logic [11:0] off_t2h_ext         = 12'h08c;
  localparam logic [11:0] off_run_control     = 12'h090;
  localparam logic [11:0] off_bvr_base        = 12'h100;
  localparam logic [11:0] off_bcr_base        = 12'h140;
  localparam logic [11:0] off_wvr_base        = 12'h180;
  localparam logic [11:0] off_wcr_base        = 12'h1c0;
  // ==========================================
  // Coprocessor register numbers (offset divided by four)
  localparam logic [9:0]  cp_debug_id         = 10'h000;
  localparam logic [9:0]  cp_rom_addr         = 10'h3f0;
  localparam logic [9:0]  cp_self_addr        = 10'h3f1;
  localparam logic [9:0]  cp_status_int       = 10'h3f2;
  localparam logic [9:0]  cp_transfer_int     = 10'h3f3;
  // ==========================================
  // Field positions
  localparam int          addr_sel_bit        = 12;
  localparam int          halted_bit          = 0;
  localparam int          halt_req_bit        = 0;
  localparam int          restart_req_bit     = 1;
  localparam int          rx_full_bit         = 30;
  localparam int          tx_full_bit         = 29;
  localparam int          ctxid_pair_lo       = 4;
  localparam logic [31:0] bvr_addr_mask       = 32'hffff_fffc;
  localparam logic [31:0] status_wr_mask      = 32'h0000_fffc;
  localparam int          num_brp             = 6;
  localparam int          num_wrp             = 4;
  // ==========================================
  // Reset and identity values, arbitrary
  localparam logic [31:0] debug_id_value      = 32'h1510_0000;
  localparam logic [31:0] rom_addr_value      = 32'h0000_0003;
  localparam logic [31:0] self_addr_value     = 32'h0001_0003;
endpackage

/* hw/dra_top.sv */
`timescale 1ns/1ps
// How it works
// - Six breakpoint pairs, pairs four/five context-capable
// - Exactly four watchpoint pairs
// - Core and SIMD resets ignored here
// - Debug reset keeps the halted flag
// - Debug reset drops pending halt request
// - APB decodes only when address bit 12 low
// - ROM, self, internal views coprocessor only
// - External status and transfer views on APB
// - Debug registers mapped to coprocessor accesses
// - APB slave port into the debug unit
// - Baseline, extended coprocessor and external paths
// - Watch fault address stays read/write
module dra_top #(
  parameter int addr_width = 13
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  debug_logic_reset_n,
  input  wire logic                  core_reset_n,
  input  wire logic                  simd_unit_reset_n,
  input  wire logic [addr_width-1:0] debug_apb_address,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  cp_valid,
  input  wire logic                  cp_extended,
  input  wire logic                  cp_write,
  input  wire logic [9:0]            cp_regnum,
  input  wire logic [31:0]           cp_wdata,
  output logic [31:0]                cp_rdata,
  output logic                       cp_done,
  output logic                       cp_undef,
  input  wire logic [31:0]           pc_value,
  input  wire logic                  core_halted_event,
  input  wire logic                  core_restarted_event,
  input  wire logic                  watch_hit,
  input  wire logic [31:0]           watch_hit_address,
  output logic                       halt_request,
  output logic                       restart_request,
  output logic                       itr_valid,
  output logic [31:0]                itr_data,
  output logic                       halted_flag
);

  // ==========================================
  // Storage
  logic [31:0] bvr [dra_pkg::num_brp];
  logic [31:0] bcr [dra_pkg::num_brp];
  logic [31:0] wvr [dra_pkg::num_wrp];
  logic [31:0] wcr [dra_pkg::num_wrp];
  logic [31:0] watch_fault_address;
  logic [31:0] vector_catch;
  logic [31:0] status_ctrl;
  logic [31:0] h2t_data;
  logic [31:0] t2h_data;
  logic        rx_full;
  logic        tx_full;
  logic        halt_request_bit;
  logic [31:0] pc_sample;

  // ==========================================
  // Access decode
  logic        dbg_rst;
  logic        apb_acc;
  logic        apb_wr;
  logic        apb_rd;
  logic [11:0] apb_off;
  logic        cp_wr;
  logic        cp_rd;
  logic [11:0] cp_off;

  // Core and SIMD resets are deliberately not used by any register
  // system reset or debug reset only
  assign dbg_rst = !resetn || !debug_logic_reset_n;
  assign apb_acc = psel && penable && !pready;
  assign apb_wr  = apb_acc && pwrite && !debug_apb_address[dra_pkg::addr_sel_bit];
  assign apb_rd  = apb_acc && !pwrite && !debug_apb_address[dra_pkg::addr_sel_bit];
  assign apb_off = {debug_apb_address[11:2], 2'b00};
  assign cp_off  = {cp_regnum, 2'b00};
  assign cp_wr   = cp_valid && cp_write && !cp_done;
  assign cp_rd   = cp_valid && !cp_write && !cp_done;

  function automatic logic in_bank(input logic [11:0] off, input logic [11:0] base, input int n);
    in_bank = off >= base && off < base + 12'(4 * n);
  endfunction

  function automatic int idx(input logic [11:0] off, input logic [11:0] base);
    idx = int'((off - base) >> 2);
  endfunction

  // Shared read view; coprocessor and APB see the same external registers, except the PC sample at 0x084, which APB alone reads
  function automatic logic [31:0] read_common(input logic [11:0] off);
    read_common = 32'h0000_0000;
    if (in_bank(off, dra_pkg::off_bvr_base, dra_pkg::num_brp)) begin
      read_common = bvr[idx(off, dra_pkg::off_bvr_base)];
    end else if (in_bank(off, dra_pkg::off_bcr_base, dra_pkg::num_brp)) begin
      read_common = bcr[idx(off, dra_pkg::off_bcr_base)];
    end else if (in_bank(off, dra_pkg::off_wvr_base, dra_pkg::num_wrp)) begin
      read_common = wvr[idx(off, dra_pkg::off_wvr_base)];
    end else if (in_bank(off, dra_pkg::off_wcr_base, dra_pkg::num_wrp)) begin
      read_common = wcr[idx(off, dra_pkg::off_wcr_base)];
    end else begin
      unique case (off)
        dra_pkg::off_debug_id:     read_common = dra_pkg::debug_id_value;
        dra_pkg::off_watch_fault:  read_common = watch_fault_address;
        dra_pkg::off_vector_catch: read_common = vector_catch;
        dra_pkg::off_h2t_ext:      read_common = h2t_data;
        dra_pkg::off_status_ext:   read_common = status_ctrl;
        dra_pkg::off_t2h_ext:      read_common = t2h_data;
        default:                   read_common = 32'h0000_0000;
      endcase
    end
  endfunction

  // ==========================================
  // APB response, access phase with one wait state
  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc;
      pslverr <= 1'b0;
      if (apb_rd) begin
        if (apb_off == dra_pkg::off_itr_pcs) begin
          prdata <= pc_sample;
        end else begin
          prdata <= read_common(apb_off);
        end
      end else if (apb_acc) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================
  // Coprocessor response
  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      cp_done  <= 1'b0;
      cp_undef <= 1'b0;
      cp_rdata <= 32'h0000_0000;
    end else begin
      cp_done  <= cp_valid && !cp_done;
      cp_undef <= 1'b0;
      if (cp_rd) begin
        // baseline path serves the small set, extended the rest
        unique case (cp_regnum)
          dra_pkg::cp_debug_id:     cp_rdata <= dra_pkg::debug_id_value;
          dra_pkg::cp_rom_addr:     cp_rdata <= dra_pkg::rom_addr_value;
          dra_pkg::cp_self_addr:    cp_rdata <= dra_pkg::self_addr_value;
          dra_pkg::cp_status_int:   cp_rdata <= status_ctrl;
          dra_pkg::cp_transfer_int: cp_rdata <= h2t_data;
          default: begin
            cp_rdata <= cp_extended ? read_common(cp_off) : 32'h0000_0000;
            cp_undef <= !cp_extended;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Breakpoint and watchpoint banks
  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      for (int i = 0; i < dra_pkg::num_brp; i++) begin
        bvr[i] <= 32'h0000_0000;
        bcr[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < dra_pkg::num_wrp; i++) begin
        wvr[i] <= 32'h0000_0000;
        wcr[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < dra_pkg::num_brp; i++) begin
        if ((apb_wr && apb_off == dra_pkg::off_bvr_base + 12'(4 * i)) ||
            (cp_wr && cp_extended && cp_off == dra_pkg::off_bvr_base + 12'(4 * i))) begin
          // low bits kept zero without context compare
          bvr[i] <= (apb_wr ? pwdata : cp_wdata) &
                    (i >= dra_pkg::ctxid_pair_lo ? 32'hffff_ffff : dra_pkg::bvr_addr_mask);
        end
        if ((apb_wr && apb_off == dra_pkg::off_bcr_base + 12'(4 * i)) ||
            (cp_wr && cp_extended && cp_off == dra_pkg::off_bcr_base + 12'(4 * i))) begin
          bcr[i] <= apb_wr ? pwdata : cp_wdata;
        end
      end
      for (int i = 0; i < dra_pkg::num_wrp; i++) begin
        if ((apb_wr && apb_off == dra_pkg::off_wvr_base + 12'(4 * i)) ||
            (cp_wr && cp_extended && cp_off == dra_pkg::off_wvr_base + 12'(4 * i))) begin
          wvr[i] <= apb_wr ? pwdata : cp_wdata;
        end
        if ((apb_wr && apb_off == dra_pkg::off_wcr_base + 12'(4 * i)) ||
            (cp_wr && cp_extended && cp_off == dra_pkg::off_wcr_base + 12'(4 * i))) begin
          wcr[i] <= apb_wr ? pwdata : cp_wdata;
        end
      end
    end
  end

  // ==========================================
  // Fault address and vector catch
  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      watch_fault_address <= 32'h0000_0000;
      vector_catch        <= 32'h0000_0000;
    end else begin
      // hardware capture, software write loses to it
      if (watch_hit) begin
        watch_fault_address <= watch_hit_address;
      end else if (apb_wr && apb_off == dra_pkg::off_watch_fault) begin
        watch_fault_address <= pwdata;
      end else if (cp_wr && cp_extended && cp_off == dra_pkg::off_watch_fault) begin
        watch_fault_address <= cp_wdata;
      end
      if (apb_wr && apb_off == dra_pkg::off_vector_catch) begin
        vector_catch <= pwdata;
      end else if (cp_wr && cp_extended && cp_off == dra_pkg::off_vector_catch) begin
        vector_catch <= cp_wdata;
      end
    end
  end

  // ==========================================
  // Transfer registers and full flags
  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      h2t_data <= 32'h0000_0000;
      t2h_data <= 32'h0000_0000;
      rx_full  <= 1'b0;
      tx_full  <= 1'b0;
    end else begin
      if (apb_wr && apb_off == dra_pkg::off_h2t_ext) begin
        h2t_data <= pwdata;
        rx_full  <= 1'b1;
      end else if (cp_rd && cp_regnum == dra_pkg::cp_transfer_int) begin
        rx_full  <= 1'b0;
      end
      // Core write sets full; a same-cycle debugger read does not lose it
      if (cp_wr && cp_regnum == dra_pkg::cp_transfer_int) begin
        t2h_data <= cp_wdata;
        tx_full  <= 1'b1;
      end else if (apb_rd && apb_off == dra_pkg::off_t2h_ext) begin
        tx_full  <= 1'b0;
      end else if (apb_wr && apb_off == dra_pkg::off_t2h_ext) begin
        t2h_data <= pwdata;
      end
    end
  end

  // ==========================================
  // Status/control and halted flag
  // debug reset keeps flag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      halted_flag <= 1'b0;
    end else if (core_halted_event) begin
      halted_flag <= 1'b1;
    end else if (core_restarted_event) begin
      halted_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      status_ctrl <= 32'h0000_0000;
    end else if (apb_wr && apb_off == dra_pkg::off_status_ext) begin
      status_ctrl <= pwdata & dra_pkg::status_wr_mask;
    end else begin
      status_ctrl[dra_pkg::halted_bit]  <= halted_flag;
      status_ctrl[dra_pkg::rx_full_bit] <= rx_full;
      status_ctrl[dra_pkg::tx_full_bit] <= tx_full;
    end
  end

  // ==========================================
  // Run control, instruction transfer, PC sample
  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      halt_request_bit <= 1'b0;
      halt_request     <= 1'b0;
      restart_request  <= 1'b0;
    end else begin
      restart_request <= apb_wr && apb_off == dra_pkg::off_run_control && pwdata[dra_pkg::restart_req_bit];
      if (apb_wr && apb_off == dra_pkg::off_run_control && pwdata[dra_pkg::halt_req_bit]) begin
        halt_request_bit <= 1'b1;
      end else if (core_halted_event) begin
        halt_request_bit <= 1'b0;
      end
      halt_request <= halt_request_bit && !core_halted_event;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (dbg_rst) begin
      itr_valid <= 1'b0;
      itr_data  <= 32'h0000_0000;
      pc_sample <= 32'h0000_0000;
    end else begin
      itr_valid <= apb_wr && apb_off == dra_pkg::off_itr_pcs;
      if (apb_wr && apb_off == dra_pkg::off_itr_pcs) begin
        itr_data <= pwdata;
      end
      if (!(apb_rd && apb_off == dra_pkg::off_itr_pcs)) begin
        pc_sample <= pc_value;
      end
    end
  end

endmodule

/* test/dra_checker.sv */
`timescale 1ns/1ps
// ==========
// Port checker
module dra_checker #(
  parameter int addr_width = 13
) (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  debug_logic_reset_n,
  input wire logic [addr_width-1:0] debug_apb_address,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  cp_valid,
  input wire logic                  cp_done,
  input wire logic                  core_halted_event,
  input wire logic                  core_restarted_event,
  input wire logic                  halt_request,
  input wire logic                  restart_request,
  input wire logic                  itr_valid,
  input wire logic [31:0]           itr_data,
  input wire logic                  halted_flag
);
  wire take = psel && penable && !pready;
  wire run_wr = take && pwrite && debug_apb_address == addr_width'(12'h090);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========
  // Assertions
  a_apb_answer: assert property (take |=> pready)
    else $error("apb access not answered");
  a_cp_answer: assert property (cp_valid && !cp_done |=> cp_done)
    else $error("coprocessor access not answered");
  a_bit12_zero: assert property (take && !pwrite && debug_apb_address[12] |=> prdata == 32'h0)
    else $error("upper space read not zero");
  a_itr_pulse: assert property (take && pwrite && debug_apb_address == addr_width'(12'h084)
    |=> itr_valid && itr_data == $past(pwdata) ##1 !itr_valid) else $error("instruction pulse wrong");
  a_restart_pulse: assert property (run_wr && pwdata[1] |=> restart_request ##1 !restart_request)
    else $error("restart pulse wrong");
  // Request is registered twice, so it shows two edges after the take
  a_halt_delay: assert property (run_wr && pwdata[0] && debug_logic_reset_n |-> ##2 halt_request)
    else $error("halt request not raised");
  a_halt_holds: assert property (halt_request && !core_halted_event && debug_logic_reset_n |=> halt_request)
    else $error("halt request lost");
  a_halt_drop: assert property (!debug_logic_reset_n |=> !halt_request)
    else $error("halt request survives debug reset");
  a_halted_keep: assert property (!debug_logic_reset_n && !core_halted_event && !core_restarted_event
    |=> $stable(halted_flag)) else $error("halted flag moved in debug reset");
endmodule
bind dra_top dra_checker #(.addr_width(addr_width)) u_chk (
  .sys_clk, .resetn, .debug_logic_reset_n, .debug_apb_address, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .cp_valid, .cp_done, .core_halted_event, .core_restarted_event,
  .halt_request, .restart_request, .itr_valid, .itr_data, .halted_flag
);

/* test/dra_debugger.sv */
`timescale 1ns/1ps
// ==========
// Debugger side of the APB port
module dra_debugger (
  input  wire logic        sys_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [12:0]      debug_apb_address,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    debug_apb_address = 13'h1fff;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [12:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge sys_clk);
    #1;
    psel = 1'b1;
    pwrite = wr;
    debug_apb_address = a;
    pwdata = d;
    @(posedge sys_clk);
    #1;
    penable = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    ok = (pready === 1'b1);
    #1;
    psel = 1'b0;
    penable = 1'b0;
    // Released lines carry junk so stale values never pass
    pwrite = ~wr;
    debug_apb_address = ~a;
    pwdata = ~d;
  endtask
endmodule

/* test/debug_register_access_unit_test.sv */
`timescale 1ns/1ps
module debug_register_access_unit_test;
  logic        sys_clk, pready, pslverr, psel, penable, pwrite, cp_done, cp_undef, u;
  logic        resetn = 1'b0, debug_logic_reset_n = 1'b0, core_reset_n = 1'b1, simd_unit_reset_n = 1'b1;
  logic        cp_valid = 1'b0, cp_extended = 1'b0, cp_write = 1'b0, watch_hit = 1'b0;
  logic        core_halted_event = 1'b0, core_restarted_event = 1'b0;
  logic        halt_request, restart_request, itr_valid, halted_flag;
  logic [9:0]  cp_regnum = 10'h0;
  logic [12:0] debug_apb_address;
  logic [31:0] cp_wdata = 32'h0, pc_value = 32'h0, watch_hit_address = 32'h0;
  logic [31:0] pwdata, prdata, cp_rdata, itr_data, q, v, w;
  int          num_errors = 0, n_checks = 0;
  dra_top u_dut (
    .sys_clk, .resetn, .debug_logic_reset_n, .core_reset_n, .simd_unit_reset_n, .debug_apb_address,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .cp_valid, .cp_extended, .cp_write,
    .cp_regnum, .cp_wdata, .cp_rdata, .cp_done, .cp_undef, .pc_value, .core_halted_event,
    .core_restarted_event, .watch_hit, .watch_hit_address, .halt_request, .restart_request,
    .itr_valid, .itr_data, .halted_flag
  );
  dra_debugger u_host (.sys_clk, .pready, .prdata, .psel, .penable, .pwrite, .debug_apb_address, .pwdata);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ==========
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
    logic ok;
    u_host.xfer(wr, a, d, q, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    chk("pslverr", 32'(pslverr), 32'h0);
  endtask
  task automatic cp(input logic ext, input logic wr, input logic [9:0] n, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    #1;
    cp_valid = 1'b1;
    cp_extended = ext;
    cp_write = wr;
    cp_regnum = n;
    cp_wdata = d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (cp_done !== 1'b1 && k < 16);
    q = cp_rdata;
    u = cp_undef;
    if (cp_done !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    #1;
    cp_valid = 1'b0;
    cp_regnum = ~n;
    cp_wdata = ~d;
  endtask
  // Low two address bits read zero on the pairs without context compare
  function automatic logic [31:0] pair_exp(input int i, input int num, input logic [31:0] d);
    if (i >= num)
      return 32'h0;
    return (i < dra_pkg::ctxid_pair_lo) ? (d & dra_pkg::bvr_addr_mask) : d;
  endfunction
  // ==========
  // Scenarios
  initial begin
    v = $urandom(32'h165d93e3);
    pc_value = $urandom();
    tick(3);
    resetn = 1'b1;
    debug_logic_reset_n = 1'b1;
    cp(1'b0, 1'b0, 10'h000, 32'h0);
    chk("debug_id", q, dra_pkg::debug_id_value);
    cp(1'b0, 1'b0, dra_pkg::cp_rom_addr, 32'h0);
    chk("rom_addr", q, dra_pkg::rom_addr_value);
    cp(1'b0, 1'b0, dra_pkg::cp_self_addr, 32'h0);
    chk("self_addr", q, dra_pkg::self_addr_value);
    cp(1'b0, 1'b0, 10'h006, 32'h0);
    chk("baseline_undef", 32'(u), 32'h1);
    apb(1'b0, {1'b0, dra_pkg::cp_rom_addr, 2'b00}, 32'h0);
    chk("rom_on_apb", q, 32'h0);
    $display("test paths done");
    v = $urandom();
    apb(1'b1, 13'h0018, v);
    cp(1'b1, 1'b0, 10'h006, 32'h0);
    chk("wfar_cp", q, v);
    chk("ext_defined", 32'(u), 32'h0);
    apb(1'b1, 13'h001c, ~v);
    cp(1'b1, 1'b0, 10'h007, 32'h0);
    chk("vcr_cp", q, ~v);
    apb(1'b1, 13'h1018, ~v);
    apb(1'b0, 13'h1018, 32'h0);
    chk("upper_read", q, 32'h0);
    apb(1'b0, 13'h0018, 32'h0);
    chk("upper_write", q, v);
    watch_hit_address = $urandom();
    watch_hit = 1'b1;
    tick(1);
    watch_hit = 1'b0;
    apb(1'b0, 13'h0018, 32'h0);
    chk("wfar_hit", q, watch_hit_address);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 13'h0024 + 13'(4 * i), $urandom());
      apb(1'b0, 13'h0024 + 13'(4 * i), 32'h0);
      chk("unimpl", q, 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      v = $urandom();
      w = $urandom() & 32'hffff_fffc;
      apb(1'b1, 13'h0100 + 13'(4 * i), v);
      apb(1'b1, 13'h0180 + 13'(4 * i), w);
      apb(1'b0, 13'h0100 + 13'(4 * i), 32'h0);
      chk("bvr", q, pair_exp(i, dra_pkg::num_brp, v));
      apb(1'b0, 13'h0180 + 13'(4 * i), 32'h0);
      chk("wvr", q, pair_exp(i, dra_pkg::num_wrp, w));
      apb(1'b1, 13'h0140 + 13'(4 * i), v);
      apb(1'b1, 13'h01c0 + 13'(4 * i), w);
      apb(1'b0, 13'h0140 + 13'(4 * i), 32'h0);
      chk("bcr", q, (i < dra_pkg::num_brp) ? v : 32'h0);
      apb(1'b0, 13'h01c0 + 13'(4 * i), 32'h0);
      chk("wcr", q, (i < dra_pkg::num_wrp) ? w : 32'h0);
    end
    $display("test registers done");
    v = $urandom();
    w = $urandom();
    apb(1'b1, 13'h0080, v);
    cp(1'b0, 1'b0, 10'h3f3, 32'h0);
    chk("rx_data", q, v);
    cp(1'b0, 1'b1, 10'h3f3, w);
    apb(1'b0, 13'h0088, 32'h0);
    chk("rx_tx_flags", 32'({q[dra_pkg::rx_full_bit], q[dra_pkg::tx_full_bit]}), 32'h1);
    apb(1'b0, 13'h008c, 32'h0);
    chk("tx_data", q, w);
    apb(1'b1, 13'h0084, v);
    chk("itr_data", itr_data, v);
    apb(1'b0, 13'h0084, 32'h0);
    chk("pc_sample", q, pc_value);
    $display("test transfers done");
    apb(1'b1, 13'h0090, 32'h1);
    core_reset_n = 1'b0;
    simd_unit_reset_n = 1'b0;
    tick(3);
    core_reset_n = 1'b1;
    simd_unit_reset_n = 1'b1;
    chk("halt_kept", 32'(halt_request), 32'h1);
    apb(1'b0, 13'h0018, 32'h0);
    chk("wfar_kept", q, watch_hit_address);
    core_halted_event = 1'b1;
    tick(1);
    core_halted_event = 1'b0;
    chk("halted", 32'({halted_flag, halt_request}), 32'h2);
    apb(1'b1, 13'h0090, 32'h1);
    tick(2);
    debug_logic_reset_n = 1'b0;
    tick(1);
    debug_logic_reset_n = 1'b1;
    chk("halt_dropped", 32'({halted_flag, halt_request}), 32'h2);
    apb(1'b0, 13'h0088, 32'h0);
    chk("status_halted", 32'(q[dra_pkg::halted_bit]), 32'h1);
    cp(1'b0, 1'b0, dra_pkg::cp_status_int, 32'h0);
    chk("status_int", 32'(q[dra_pkg::halted_bit]), 32'h1);
    apb(1'b0, 13'h0110, 32'h0);
    chk("bvr4_cleared", q, 32'h0);
    apb(1'b1, 13'h0090, 32'h2);
    core_restarted_event = 1'b1;
    tick(1);
    core_restarted_event = 1'b0;
    chk("restarted", 32'(halted_flag), 32'h0);
    $display("test halt control done");
    end_of_test();
  end
endmodule
